// ==== logic/mfad_decoder.sv ====
// Memory-format instruction decoder with effective-address generation
//
// What this block does
// - First-word bit 12 clear selects short format, set selects extended.
// - An 8-bit opcode is extracted in both sub-formats.
// - Short-format offset is an unsigned byte offset.
// - Short mode 00: address is offset alone; base ignored; one word.
// - Short mode 10: address is base register plus offset; one word.
// - Extended 0100 gives base; 0111 gives base plus scaled index.
// - Extended 1100..1111 add displacement to none, base, index, or both.
// - Two-word modes take displacement from next word, skip both words.
// - Displacement is a 32-bit signed two's complement addend.
// - Mode 0101: current instruction address plus displacement plus 8.
// - Mode 0110 is reserved, may fault, gives no defined address.
// - Scale 000..100 multiply the index by 1, 2, 4, 8, 16.
// - Scale 101..111 are reserved; result undefined, not relied upon.
// - For loads the operand register names the first destination.
// - For stores the operand register names the first data source.
// - Instruction and displacement words are word sized and aligned.
`timescale 1ns/1ps
`default_nettype none
module mfad_decoder (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        IW_VALID,
  input  wire logic [31:0] IW_DATA,
  input  wire logic [31:0] IW_ADDR,
  output var  logic        IW_READY,
  output var  logic [4:0]  RF_BASE_SEL,
  output var  logic [4:0]  RF_INDEX_SEL,
  input  wire logic [31:0] RF_BASE_VAL,
  input  wire logic [31:0] RF_INDEX_VAL,
  output var  logic        DEC_VALID,
  output var  logic        MEM_ISSUE,
  output var  logic        RSVD_FAULT,
  output var  logic [7:0]  OPCODE,
  output var  logic [4:0]  OPERAND_REG,
  output var  logic [31:0] EFF_ADDR,
  output var  logic [31:0] NEXT_IP
);
  // ----------------------------------------------------------------
  // State and held fields
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_DISP, S_CALC} mfad_state_t;
  mfad_state_t state_q;
  logic        ready_q;
  logic        short_q;
  logic        smode_q;
  logic [3:0]  xmode_q;
  logic [11:0] ofs_q;
  logic [2:0]  scale_q;
  logic [31:0] disp_q;
  logic [31:0] ip_q;
  logic [31:0] step_q;
  logic [7:0]  opc_q;
  logic [4:0]  oper_q;
  logic [4:0]  bsel_q;
  logic [4:0]  isel_q;
  logic        valid_q;
  logic        issue_q;
  logic        fault_q;
  logic [31:0] ea_q;
  logic [31:0] nip_q;
  logic        take;
  logic        is_short;
  logic        two_word;
  logic [3:0]  w_xmode;
  mfad_ea_if   ea_if ();

  // ----------------------------------------------------------------
  // First-word decode
  // ----------------------------------------------------------------
  // Bit 12 picks the sub-format; it also doubles as mode bit 2 in extended form
  assign take     = IW_VALID && ready_q;
  assign is_short = !IW_DATA[mfad_pkg::FMT_BIT];
  assign w_xmode  = IW_DATA[mfad_pkg::XMODE_LSB +: mfad_pkg::XMODE_W];
  // Mode bit 3 set or 0101 means a trailing displacement word
  assign two_word = !is_short && (w_xmode[3] || w_xmode == mfad_pkg::XMODE_IPDISP);

  // Sequencer: word, optional displacement word, then address cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      ready_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          ready_q <= 1'b1;
          if (take) begin
            state_q <= two_word ? S_DISP : S_CALC;
            ready_q <= two_word;
          end
        end
        S_DISP: begin
          if (take) begin
            state_q <= S_CALC;
            ready_q <= 1'b0;
          end
        end
        S_CALC: begin
          state_q <= S_IDLE;
          ready_q <= 1'b1;
        end
        default: begin
          state_q <= S_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // Field capture on the first word; register selects go out at once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      short_q <= 1'b1;
      smode_q <= mfad_pkg::SMODE_ABS;
      xmode_q <= mfad_pkg::XMODE_BASE;
      ofs_q   <= 12'h000;
      scale_q <= 3'h0;
      ip_q    <= mfad_pkg::RESET_WORD;
      step_q  <= mfad_pkg::WORD_BYTES;
      opc_q   <= mfad_pkg::RESET_OPC;
      oper_q  <= mfad_pkg::RESET_REG;
      bsel_q  <= mfad_pkg::RESET_REG;
      isel_q  <= mfad_pkg::RESET_REG;
    end else if (take && state_q == S_IDLE) begin
      short_q <= is_short;
      smode_q <= IW_DATA[mfad_pkg::SMODE_BIT];
      xmode_q <= w_xmode;
      ofs_q   <= IW_DATA[mfad_pkg::OFS_LSB +: mfad_pkg::OFS_W];
      scale_q <= IW_DATA[mfad_pkg::SCALE_LSB +: mfad_pkg::SCALE_W];
      ip_q    <= {IW_ADDR[31:2], 2'b00};
      step_q  <= two_word ? (mfad_pkg::WORD_BYTES << 1) : mfad_pkg::WORD_BYTES;
      opc_q   <= IW_DATA[mfad_pkg::OPC_LSB +: mfad_pkg::OPC_W];
      oper_q  <= IW_DATA[mfad_pkg::OPER_LSB +: mfad_pkg::REG_W];
      bsel_q  <= IW_DATA[mfad_pkg::BASE_LSB +: mfad_pkg::REG_W];
      isel_q  <= IW_DATA[mfad_pkg::INDEX_LSB +: mfad_pkg::REG_W];
    end
  end

  // Displacement comes from the word right after the instruction
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      disp_q <= mfad_pkg::RESET_WORD;
    end else if (state_q == S_IDLE && take) begin
      disp_q <= mfad_pkg::RESET_WORD;      // One-word modes add nothing
    end else if (state_q == S_DISP && take) begin
      disp_q <= IW_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  // Register file answers in the cycle the select goes out; its values are used in S_CALC
  assign ea_if.short_fmt  = short_q;
  assign ea_if.short_mode = smode_q;
  assign ea_if.ext_mode   = xmode_q;
  assign ea_if.offset     = ofs_q;
  assign ea_if.scale      = scale_q;
  assign ea_if.base_val   = RF_BASE_VAL;
  assign ea_if.index_val  = RF_INDEX_VAL;
  assign ea_if.disp       = disp_q;
  assign ea_if.ip         = ip_q;

  mfad_agen u_agen (
    .e (ea_if.agen)
  );

  // Result stage; a reserved mode reports a fault and never issues
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      valid_q <= 1'b0;
      issue_q <= 1'b0;
      fault_q <= 1'b0;
      ea_q    <= mfad_pkg::RESET_WORD;
      nip_q   <= mfad_pkg::RESET_WORD;
    end else begin
      valid_q <= state_q == S_CALC;
      issue_q <= state_q == S_CALC && !(!short_q && xmode_q == mfad_pkg::XMODE_RSVD);
      fault_q <= state_q == S_CALC && !short_q && xmode_q == mfad_pkg::XMODE_RSVD;
      if (state_q == S_CALC) begin
        ea_q  <= ea_if.ea;
        nip_q <= ip_q + step_q;
      end
    end
  end

  // Port drive, all straight from flops
  assign IW_READY     = ready_q;
  assign RF_BASE_SEL  = bsel_q;
  assign RF_INDEX_SEL = isel_q;
  assign DEC_VALID    = valid_q;
  assign MEM_ISSUE    = issue_q;
  assign RSVD_FAULT   = fault_q;
  assign OPCODE       = opc_q;
  assign OPERAND_REG  = oper_q;
  assign EFF_ADDR     = ea_q;
  assign NEXT_IP      = nip_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_fault_no_issue: assert property (@(posedge CLK) disable iff (RST)
    RSVD_FAULT |-> DEC_VALID && !MEM_ISSUE) else $error("fault with access");
  a_rsvd_flagged: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && !short_q && xmode_q == mfad_pkg::XMODE_RSVD) |=> RSVD_FAULT)
    else $error("reserved mode not flagged");
  a_issue_valid: assert property (@(posedge CLK) disable iff (RST)
    DEC_VALID |-> (MEM_ISSUE != RSVD_FAULT)) else $error("issue and fault disagree");
  a_one_word_ip: assert property (@(posedge CLK) disable iff (RST)
    (take && state_q == S_IDLE && is_short) ##1 1'b1 ##1 DEC_VALID
      |-> NEXT_IP == $past(ip_q) + mfad_pkg::WORD_BYTES) else $error("bad one-word ip");
  a_two_word_ip: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_DISP && take) ##1 1'b1 ##1 DEC_VALID
      |-> NEXT_IP == $past(ip_q, 2) + (mfad_pkg::WORD_BYTES << 1)) else $error("bad two-word ip");
  a_abs_offset: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && short_q && smode_q == mfad_pkg::SMODE_ABS)
      |=> EFF_ADDR == {20'h0_0000, $past(ofs_q)}) else $error("bad absolute offset");
  a_base_offset: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && short_q && smode_q == mfad_pkg::SMODE_BASEOFS)
      |=> EFF_ADDR == $past(RF_BASE_VAL) + {20'h0_0000, $past(ofs_q)}) else $error("bad base+ofs");
  a_ip_disp: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && !short_q && xmode_q == mfad_pkg::XMODE_IPDISP)
      |=> EFF_ADDR == $past(ip_q) + $past(disp_q) + mfad_pkg::IP_BIAS) else $error("bad ip+disp");
  a_index_scale: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && !short_q && xmode_q == mfad_pkg::XMODE_IDISP
      && scale_q <= mfad_pkg::SCALE_MAX)
      |=> EFF_ADDR == ($past(RF_INDEX_VAL) << $past(scale_q)) + $past(disp_q))
    else $error("bad scaled index");
  a_disp_wait: assert property (@(posedge CLK) disable iff (RST)
    (take && state_q == S_IDLE && two_word) |=> state_q == S_DISP && IW_READY)
    else $error("displacement word not awaited");
  c_short: cover property (@(posedge CLK) disable iff (RST)
    DEC_VALID && MEM_ISSUE && $past(short_q, 2));
  c_two_word: cover property (@(posedge CLK) disable iff (RST)
    state_q == S_DISP ##1 state_q == S_CALC);
  c_fault: cover property (@(posedge CLK) disable iff (RST) RSVD_FAULT);
  c_back2back: cover property (@(posedge CLK) disable iff (RST) DEC_VALID ##2 DEC_VALID);
endmodule
`default_nettype wire

// ==== pkg/mfad_pkg.sv ====
// Constants and types shared by the memory-format address decoder
`default_nettype none
package mfad_pkg;
  // ----------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------
  localparam int          WORD_W      = 32;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [31:0] IP_BIAS     = 32'h0000_0008;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [4:0]  RESET_REG   = 5'h00;
  localparam logic [7:0]  RESET_OPC   = 8'h00;
  // ----------------------------------------------------------------
  // Field layout of the first instruction word
  // ----------------------------------------------------------------
  localparam int OPC_LSB   = 24;
  localparam int OPC_W     = 8;
  localparam int OPER_LSB  = 19;
  localparam int REG_W     = 5;
  localparam int BASE_LSB  = 14;
  localparam int FMT_BIT   = 12;
  localparam int SMODE_BIT = 13;
  localparam int XMODE_LSB = 10;
  localparam int XMODE_W   = 4;
  localparam int OFS_LSB   = 0;
  localparam int OFS_W     = 12;
  localparam int SCALE_LSB = 7;
  localparam int SCALE_W   = 3;
  localparam int INDEX_LSB = 0;
  // ----------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------
  localparam logic       SMODE_ABS     = 1'b0;  // Mode 00
  localparam logic       SMODE_BASEOFS = 1'b1;  // Mode 10
  localparam logic [3:0] XMODE_BASE    = 4'h4;  // 0100
  localparam logic [3:0] XMODE_IPDISP  = 4'h5;  // 0101
  localparam logic [3:0] XMODE_RSVD    = 4'h6;  // 0110
  localparam logic [3:0] XMODE_BASEIDX = 4'h7;  // 0111
  localparam logic [3:0] XMODE_DISP    = 4'hC;  // 1100
  localparam logic [3:0] XMODE_BDISP   = 4'hD;  // 1101
  localparam logic [3:0] XMODE_IDISP   = 4'hE;  // 1110
  localparam logic [3:0] XMODE_BIDISP  = 4'hF;  // 1111
  localparam logic [2:0] SCALE_MAX     = 3'h4;  // x16
endpackage
`default_nettype wire

// ==== pkg/mfad_ea_if.sv ====
// Carrier between the decoder and its address generator
`timescale 1ns/1ps
`default_nettype none
interface mfad_ea_if;
  logic        short_fmt;
  logic        short_mode;
  logic [3:0]  ext_mode;
  logic [11:0] offset;
  logic [2:0]  scale;
  logic [31:0] base_val;
  logic [31:0] index_val;
  logic [31:0] disp;
  logic [31:0] ip;
  logic [31:0] ea;
  modport dec  (output short_fmt, short_mode, ext_mode, offset, scale, base_val,
                output index_val, disp, ip, input ea);
  modport agen (input short_fmt, short_mode, ext_mode, offset, scale, base_val,
                input index_val, disp, ip, output ea);
endinterface
`default_nettype wire

// ==== logic/mfad_agen.sv ====
// Effective-address adder for both memory sub-formats
`timescale 1ns/1ps
`default_nettype none
module mfad_agen (
  mfad_ea_if.agen e
);
  logic [31:0] scaled;
  logic [31:0] ofs_ext;

  // Index scaling; 101..111 just shift further, nobody may rely on it
  assign scaled  = e.index_val << e.scale;
  assign ofs_ext = {20'h0_0000, e.offset};

  // Address sum per mode; displacement is two's complement, so wrap = sign
  always_comb begin
    e.ea = mfad_pkg::RESET_WORD;
    if (e.short_fmt) begin
      if (e.short_mode == mfad_pkg::SMODE_ABS) begin
        e.ea = ofs_ext;
      end else begin
        e.ea = e.base_val + ofs_ext;
      end
    end else begin
      case (e.ext_mode)
        mfad_pkg::XMODE_BASE:    e.ea = e.base_val;
        mfad_pkg::XMODE_BASEIDX: e.ea = e.base_val + scaled;
        mfad_pkg::XMODE_IPDISP:  e.ea = e.ip + e.disp + mfad_pkg::IP_BIAS;
        mfad_pkg::XMODE_DISP:    e.ea = e.disp;
        mfad_pkg::XMODE_BDISP:   e.ea = e.base_val + e.disp;
        mfad_pkg::XMODE_IDISP:   e.ea = scaled + e.disp;
        mfad_pkg::XMODE_BIDISP:  e.ea = e.base_val + scaled + e.disp;
        default:                 e.ea = mfad_pkg::RESET_WORD;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/mfad_rf_model.sv ====
// Register file stand-in serving the decoder's base and index read ports
`timescale 1ns/1ps
`default_nettype none
module mfad_rf_model (
  input  wire logic [4:0]  base_sel,
  input  wire logic [4:0]  index_sel,
  output var  logic [31:0] base_val,
  output var  logic [31:0] index_val
);
  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  // Every register holds a distinct value, so a wrong select shows in the address
  always_comb begin
    base_val  = {base_sel, 3'h1, 19'h00A4C, base_sel};
    index_val = {index_sel, 3'h1, 19'h00A4C, index_sel};
  end
endmodule
`default_nettype wire

// ==== testbench/test_mfad_decoder.sv ====
// Self-checking bench for the memory-format address decoder
`timescale 1ns/1ps
`default_nettype none
module test_mfad_decoder;
  typedef struct packed {
    logic [31:0] w;
    logic [31:0] disp;
    logic [31:0] ip;
    logic [31:0] ea;
    logic [31:0] nip;
    logic        flt;
    logic        two;
  } mfad_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        iw_valid = 1'b0;
  logic [31:0] iw_data = 32'h0000_0000;
  logic [31:0] iw_addr = 32'h0000_0000;
  logic        iw_ready, dec_valid, mem_issue, rsvd_fault;
  logic [4:0]  base_sel, index_sel, operand_reg;
  logic [31:0] base_val, index_val, eff_addr, next_ip;
  logic [7:0]  opcode;
  int          n_errors = 0;
  int          compares = 0;
  mfad_row_t   rows[$];
  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  mfad_decoder mfad_decoder_i (.CLK(clk), .RST(rst), .IW_VALID(iw_valid), .IW_DATA(iw_data),
    .IW_ADDR(iw_addr), .IW_READY(iw_ready), .RF_BASE_SEL(base_sel), .RF_INDEX_SEL(index_sel),
    .RF_BASE_VAL(base_val), .RF_INDEX_VAL(index_val), .DEC_VALID(dec_valid),
    .MEM_ISSUE(mem_issue), .RSVD_FAULT(rsvd_fault), .OPCODE(opcode),
    .OPERAND_REG(operand_reg), .EFF_ADDR(eff_addr), .NEXT_IP(next_ip));
  mfad_rf_model mfad_rf_model_i (.base_sel(base_sel), .index_sel(index_sel),
    .base_val(base_val), .index_val(index_val));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rv(input logic [4:0] r);
    rv = {r, 3'h1, 19'h00A4C, r};
  endfunction
  // Extended word: opcode, operand, base, mode, scale, index
  function automatic logic [31:0] xw(input logic [3:0] m, input logic [4:0] b,
      input logic [2:0] s, input logic [4:0] x, input logic [4:0] o);
    xw = {~o, 3'h3, o, b, m, s, 2'h0, x};
  endfunction
  function automatic logic [31:0] sw(input logic m, input logic [4:0] b,
      input logic [11:0] ofs, input logic [4:0] o);
    sw = {~o, 3'h3, o, b, m, 1'b0, ofs};
  endfunction
  task automatic add(input logic [31:0] w, disp, ip, ea, nip, input logic flt, two);
    rows.push_back({w, disp, ip, ea, nip, flt, two});
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic exp, got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // One cycle on, settled; a handshake that never comes ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    #10;
    n++;
    if (n > 40) begin
      n_errors++;
      $display("ERROR handshake expected 1 seen 0");
      tally_and_finish();
    end
  endtask
  // Offer a word and hold it until the edge that takes it; caller releases,
  // so a back-to-back word never lowers and raises valid in one time step
  task automatic offer(input logic [31:0] d, a);
    int n;
    n = 0;
    iw_valid = 1'b1;
    iw_data = d;
    iw_addr = a;
    while (iw_ready !== 1'b1) tick(n);
    tick(n);
  endtask
  // Whole instruction; gap stalls the displacement word by that many cycles
  task automatic run(input mfad_row_t r, input int gap);
    int n;
    n = 0;
    offer(r.w, r.ip);
    if (r.two) begin
      if (gap > 0) begin
        iw_valid = 1'b0;
        repeat (gap) tick(n);
      end
      offer(r.disp, ~r.ip);
    end
    iw_valid = 1'b0;
    iw_data = ~r.w;
    while (dec_valid !== 1'b1) tick(n);
    chk32("rf_base_sel", {27'h0, r.w[18:14]}, {27'h0, base_sel});
    if (r.w[12]) begin
      chk32("rf_index_sel", {27'h0, r.w[4:0]}, {27'h0, index_sel});
    end
    chk32("opcode", {24'h0, r.w[31:24]}, {24'h0, opcode});
    chk32("operand_reg", {27'h0, r.w[23:19]}, {27'h0, operand_reg});
    chkb("rsvd_fault", r.flt, rsvd_fault);
    chkb("mem_issue", ~r.flt, mem_issue);
    if (!r.flt) begin
      chk32("eff_addr", r.ea, eff_addr);
      chk32("next_ip", r.nip, next_ip);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    add(sw(1'b0, 5'h05, 12'hFFF, 5'h01), 0, 32'h100, 32'hFFF, 32'h104, 0, 0);
    add(sw(1'b1, 5'h03, 12'h800, 5'h02), 0, 32'h104, rv(3) + 32'h800, 32'h108, 0, 0);
    add(xw(4'h4, 5'h07, 3'h0, 5'h00, 5'h1F), 0, 32'h108, rv(7), 32'h10C, 0, 0);
    for (int s = 0; s < 5; s++) begin
      add(xw(4'h7, 5'h02, 3'(s), 5'h09, 5'(s + 4)), 0, 32'h200,
          rv(2) + (rv(9) << s), 32'h204, 0, 0);
    end
    add(xw(4'h5, 5'h00, 3'h0, 5'h00, 5'h06), 32'hFFFF_FFF0, 32'h2003, 32'h1FF8, 32'h2008,
        0, 1);
    add(xw(4'hC, 5'h0B, 3'h0, 5'h00, 5'h07), 32'h8765_4321, 32'h300, 32'h8765_4321, 32'h308,
        0, 1);
    add(xw(4'hD, 5'h04, 3'h0, 5'h00, 5'h08), 32'hFFFF_F000, 32'h308, rv(4) + 32'hFFFF_F000,
        32'h310, 0, 1);
    add(xw(4'hE, 5'h0A, 3'h3, 5'h06, 5'h09), 32'h10, 32'h310, (rv(6) << 3) + 32'h10, 32'h318,
        0, 1);
    add(xw(4'hF, 5'h01, 3'h4, 5'h1F, 5'h0A), 32'h7FFF_FFFF, 32'h318,
        rv(1) + (rv(31) << 4) + 32'h7FFF_FFFF, 32'h320, 0, 1);
    add(xw(4'h6, 5'h01, 3'h0, 5'h00, 5'h0C), 0, 32'h320, 0, 0, 1, 0);
    repeat (3) @(posedge clk);
    #10;
    rst = 1'b0;
    // Rows run back to back: next first word offered while the result shows
    foreach (rows[i]) run(rows[i], 0);
    // Displacement word held back three cycles must still pair with its first word
    run(rows[rows.size() - 2], 3);
    // Reset between first word and displacement, then a clean instruction
    offer(rows[9].w, rows[9].ip);
    rst = 1'b1;
    iw_valid = 1'b0;
    #10;
    chkb("iw_ready", 1'b0, iw_ready);
    chkb("dec_valid", 1'b0, dec_valid);
    chk32("eff_addr", 32'h0, eff_addr);
    @(posedge clk);
    #10;
    rst = 1'b0;
    run(rows[1], 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
